// ### logic/sss_sequencer.sv
// Sleep and start-up sequencer: reset delay, OTP load, sleep and wake.
// Assumes pin input synchronous to clock; OTP read has one-cycle latency.
`timescale 1ns/1ns
`include "sss_defs.svh"
module sss_sequencer #(
  parameter int unsigned SLEEP_CYC = `SSS_SLEEP_ENTRY_CYC,
  parameter int unsigned INIT_CYC  = `SSS_INIT_MAX_CYC,
  parameter int unsigned POR_CYC   = `SSS_POR_DELAY_CYC,
  parameter int unsigned WORDS     = `SSS_OTP_WORDS,
  parameter int unsigned DW        = `SSS_OTP_WIDTH
) (
  input  wire logic                     clock,
  input  wire logic                     rst_b,
  input  wire logic                     serial_data_line_in,
  output logic                          serial_data_line_out,
  output logic                          serial_data_line_oe_b,
  input  wire logic                     func_busy,
  output logic [$clog2(WORDS)-1:0]      otp_addr,
  output logic                          otp_rd,
  input  wire logic [DW-1:0]            otp_data,
  output logic                          osc_enable,
  output logic                          sleep_en,
  output logic                          core_reset_b,
  output logic                          init_done,
  output logic                          link_ready,
  output logic [WORDS*DW-1:0]           config_regs
);
  localparam int unsigned AW = $clog2(WORDS);

  sss_pkg::sss_state_t state_r;
  logic [15:0]         por_cnt_r;
  logic [31:0]         init_cnt_r;
  logic [AW:0]         load_idx_r;
  logic                load_pend_r;
  logic [AW-1:0]       load_addr_r;
  logic [DW-1:0]       regs_r [WORDS];
  logic                line_q_r;
  logic                idle_clear;
  logic                idle_expired;
  logic                load_last;

  // Line low or busy function restarts idle count; also in non-active states
  assign idle_clear = !serial_data_line_in || func_busy
                      || (state_r != sss_pkg::SSS_ST_ACTIVE);

  sss_timer #(
    .WIDTH (32)
  ) u_idle (
    .clock   (clock),
    .rst_b   (rst_b),
    .clear   (idle_clear),
    .limit   (SLEEP_CYC[31:0]),
    .expired (idle_expired)
  );

  assign load_last = (load_idx_r == (AW+1)'(WORDS));

  // Main mode machine
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      state_r <= sss_pkg::SSS_ST_POR;
    else
    begin
      case (state_r)
        sss_pkg::SSS_ST_POR:
          if (por_cnt_r >= 16'(POR_CYC - 1))
            state_r <= sss_pkg::SSS_ST_INIT;
        sss_pkg::SSS_ST_INIT:
          // Timeout bounds the load even if OTP stalls
          if ((load_last && !load_pend_r) || init_cnt_r >= INIT_CYC - 1)
            state_r <= sss_pkg::SSS_ST_SLEEP;
        sss_pkg::SSS_ST_SLEEP:
          if (!serial_data_line_in || func_busy)
            state_r <= sss_pkg::SSS_ST_ACTIVE;
        sss_pkg::SSS_ST_ACTIVE:
          if (idle_expired)
            state_r <= sss_pkg::SSS_ST_SLEEP;
        default:
          state_r <= sss_pkg::SSS_ST_POR;
      endcase
    end
  end

  // Reset delay counter from threshold crossing
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      por_cnt_r <= 16'h0000;
    else if (state_r == sss_pkg::SSS_ST_POR)
      por_cnt_r <= por_cnt_r + 16'h0001;
  end

  // Initialisation time budget
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      init_cnt_r <= 32'h00000000;
    else if (state_r == sss_pkg::SSS_ST_INIT)
      init_cnt_r <= init_cnt_r + 32'h00000001;
  end

  // OTP read sequencing: issue address, capture next cycle
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      load_idx_r  <= '0;
      load_pend_r <= 1'b0;
      load_addr_r <= '0;
    end
    else
    begin
      load_pend_r <= otp_rd;
      load_addr_r <= otp_addr;
      if (otp_rd)
        load_idx_r <= load_idx_r + 1'b1;
    end
  end

  assign otp_rd   = (state_r == sss_pkg::SSS_ST_INIT) && !load_last;
  assign otp_addr = load_idx_r[AW-1:0];

  // Per-word register file: initial value in reset, OTP value after
  genvar gi;
  generate
    for (gi = 0; gi < WORDS; gi++)
    begin : g_reg
      always_ff @(posedge clock or negedge rst_b)
      begin
        if (!rst_b)
          regs_r[gi] <= DW'(`SSS_REG_INIT_VAL);
        else if (load_pend_r && load_addr_r == AW'(gi))
          regs_r[gi] <= otp_data;
      end
      assign config_regs[gi*DW +: DW] = regs_r[gi];
    end
  endgenerate

  // Previous line level for wake-up edge detection
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      line_q_r <= 1'b1;
    else
      line_q_r <= serial_data_line_in;
  end

  // Ready after wake-up seen; dropped on sleep or reset
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      link_ready <= 1'b0;
    else if (state_r != sss_pkg::SSS_ST_ACTIVE)
      link_ready <= 1'b0;
    else if (line_q_r && !serial_data_line_in)
      link_ready <= 1'b1;
    else if (state_r == sss_pkg::SSS_ST_ACTIVE && !line_q_r)
      link_ready <= 1'b1;
  end

  // Status flops
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      init_done    <= 1'b0;
      core_reset_b <= 1'b0;
    end
    else
    begin
      core_reset_b <= (state_r != sss_pkg::SSS_ST_POR);
      if (state_r == sss_pkg::SSS_ST_SLEEP)
        init_done <= 1'b1;
    end
  end

  // Oscillator gated in sleep; wake path is combinational so no edge is needed
  assign sleep_en   = (state_r == sss_pkg::SSS_ST_SLEEP);
  assign osc_enable = !sleep_en || !serial_data_line_in || func_busy;

  // This block never pulls the line; protocol logic owns that
  assign serial_data_line_out  = 1'b0;
  assign serial_data_line_oe_b = 1'b1;
endmodule : sss_sequencer

// ### inc/sss_defs.svh
// Constants for the sleep and start-up sequencer.
// Assumes a 50 MHz core clock; sleep and init counts are derived from printed times.
`ifndef SSS_DEFS_SVH
`define SSS_DEFS_SVH
`define SSS_CLK_MHZ          50
`define SSS_SLEEP_ENTRY_MS   2000
`define SSS_SLEEP_ENTRY_CYC  (`SSS_SLEEP_ENTRY_MS * 1000 * `SSS_CLK_MHZ)
`define SSS_INIT_MAX_US      160
`define SSS_INIT_MAX_CYC     (`SSS_INIT_MAX_US * `SSS_CLK_MHZ)
`define SSS_POR_DELAY_CYC    64
`define SSS_OTP_WORDS        8
`define SSS_OTP_WIDTH        32
`define SSS_REG_INIT_VAL     32'h00000000
`endif

// ### inc/sss_pkg.sv
// Types for the sleep and start-up sequencer.
// Assumes nothing beyond the defines header.
package sss_pkg;
  typedef enum logic [2:0] {
    SSS_ST_POR,
    SSS_ST_INIT,
    SSS_ST_SLEEP,
    SSS_ST_ACTIVE
  } sss_state_t;
endpackage : sss_pkg

// ### logic/sss_timer.sv
// Idle timer: counts while idle, flags when the limit is passed.
// Assumes a clear input that restarts the count immediately.
`timescale 1ns/1ns
module sss_timer #(
  parameter int unsigned WIDTH = 32
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic             clear,
  input  wire logic [WIDTH-1:0] limit,
  output logic                  expired
);
  logic [WIDTH-1:0] count_r;

  // Saturating count so expired stays high until cleared
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      count_r <= '0;
    else if (clear)
      count_r <= '0;
    else if (count_r <= limit)
      count_r <= count_r + 1'b1;
  end

  assign expired = (count_r > limit) && !clear;
endmodule : sss_timer

// ### sim/sss_seq_properties.sv
// Port checker for the sequencer.
// Assumes one clock and async active-low reset.
`timescale 1ns/1ns
module sss_seq_properties #(
  parameter int unsigned SLEEP_CYC = 50,
  parameter int unsigned INIT_CYC  = 8000,
  parameter int unsigned POR_CYC   = 64,
  parameter int unsigned WORDS     = 8,
  parameter int unsigned DW        = 32
) (
  input wire logic                clock,
  input wire logic                rst_b,
  input wire logic                serial_data_line_in,
  input wire logic                func_busy,
  input wire logic                sleep_en,
  input wire logic                osc_enable,
  input wire logic                core_reset_b,
  input wire logic                init_done,
  input wire logic                link_ready,
  input wire logic [WORDS*DW-1:0] config_regs
);
  int unsigned idle_r;
  int unsigned rel_r;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Idle run length, saturating just above the limit so long limits still work
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b) idle_r <= 0;
    else if (!serial_data_line_in || func_busy) idle_r <= 0;
    else if (idle_r < SLEEP_CYC + 8) idle_r <= idle_r + 1;
  // Cycles since reset release
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b) rel_r <= 0;
    else if (rel_r < 20000) rel_r <= rel_r + 1;
  a_osc_off: assert property (sleep_en && serial_data_line_in && !func_busy |-> !osc_enable)
    else $error("oscillator runs in sleep");
  a_line_wake: assert property (sleep_en && !serial_data_line_in |=> !sleep_en)
    else $error("no wake on line low");
  a_busy_wake: assert property (sleep_en && func_busy |=> !sleep_en)
    else $error("no wake on busy");
  a_no_early: assert property ($rose(sleep_en) && init_done |-> idle_r >= SLEEP_CYC)
    else $error("sleep entered early");
  a_idle_sleep: assert property (init_done && idle_r > SLEEP_CYC + 3 |-> sleep_en)
    else $error("sleep not entered");
  a_por_hold: assert property (rel_r < POR_CYC - 1 |-> !core_reset_b)
    else $error("reset delay too short");
  a_init_time: assert property (rel_r == POR_CYC + INIT_CYC |-> init_done)
    else $error("init too slow");
  a_rst_vals: assert property (@(posedge clock) disable iff (1'b0)
    !rst_b |-> config_regs == '0 && !init_done && !link_ready) else $error("reset values wrong");
  a_link_up: assert property (sleep_en && !serial_data_line_in |-> ##[1:2] link_ready)
    else $error("link not ready");
endmodule : sss_seq_properties
bind sss_sequencer sss_seq_properties #(.SLEEP_CYC(SLEEP_CYC), .INIT_CYC(INIT_CYC), .POR_CYC(POR_CYC),
  .WORDS(WORDS), .DW(DW)) u_props (.clock, .rst_b, .serial_data_line_in, .func_busy, .sleep_en,
  .osc_enable, .core_reset_b, .init_done, .link_ready, .config_regs);

// ### sim/sss_host_model.sv
// Host on the one-wire line: sends wake-up pulses.
// Assumes a pull-up and an open-drain device pin.
`timescale 1ns/1ns
module sss_host_model #(
  parameter int unsigned WAKE_CYC = 4
) (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic wake,
  input  wire logic dev_oe_b,
  output logic      line
);
  int unsigned low_r;
  // Wake-up pulse before any talk, held low a fixed stretch
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b) low_r <= 0;
    else if (wake) low_r <= WAKE_CYC;
    else if (low_r != 0) low_r <= low_r - 1;
  // Pull-up wins unless either side pulls low
  assign line = (low_r == 0) && dev_oe_b;
endmodule : sss_host_model

// ### sim/tb_top.sv
// Bench: start-up, wake, idle sleep and mid-run reset.
// Assumes the host model on the line and an OTP stub here.
`timescale 1ns/1ns
module tb_top;
  localparam int unsigned SC = 50;
  logic         clock = 0, rst_b = 0, wake = 0, func_busy = 0;
  logic         line, d_oe_b, otp_rd, osc_enable, sleep_en, init_done, link_ready;
  logic         core_reset_b, d_out;
  logic [2:0]   otp_addr, addr_q;
  logic [31:0]  otp_data = 32'h0;
  logic [255:0] cfg;
  int           fail_count = 0, n_compared = 0, cyc = 0;
  sss_sequencer #(.SLEEP_CYC(SC), .INIT_CYC(200)) DUT (.clock, .rst_b, .serial_data_line_in(line),
    .serial_data_line_out(d_out), .serial_data_line_oe_b(d_oe_b), .func_busy, .otp_addr, .otp_rd,
    .otp_data, .osc_enable, .sleep_en, .core_reset_b, .init_done, .link_ready, .config_regs(cfg));
  sss_host_model u_host (.clock, .rst_b, .wake, .dev_oe_b(d_oe_b), .line);
  initial forever #10 clock = ~clock;
  // OTP stub: word k answers the cycle after its address
  always @(posedge clock) addr_q <= otp_addr;
  always @(negedge clock) otp_data <= {29'h1B2C3D40, addr_q};
  // Hang guard, far above the roughly 700 cycles needed
  always @(posedge clock)
    if (++cyc == 3000)
    begin
      fail_count++;
      final_report();
    end
  task automatic chk(input string nm, input logic [255:0] exp, got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got);
    end
  endtask : chk
  task automatic wt(input logic v, input int lim);
    for (int n = 0; n < lim && sleep_en !== v; n++) @(negedge clock);
  endtask : wt
  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  task automatic t_start();
    // Real falling edge on reset, so the async branch fires even at time zero
    rst_b = 1;
    #1;
    rst_b = 0;
    func_busy = 0;
    repeat (5) @(negedge clock);
    chk("cfg_rst", 0, cfg);
    chk("osc_rst", 1, osc_enable);
    chk("done_rst", 0, init_done);
    chk("core_rst", 0, core_reset_b);
    chk("line_oe_b", 1, d_oe_b);
    chk("line_out", 0, d_out);
    rst_b = 1;
    wt(1, 264);
    chk("init_sleep", 1, sleep_en);
    chk("core_run", 1, core_reset_b);
    for (int i = 0; i < 8; i++) chk("otp_word", {29'h1B2C3D40, i[2:0]}, cfg[i*32+:32]);
    $display("start test done");
  endtask : t_start
  task automatic t_wake();
    wake = 1;
    @(negedge clock);
    wake = 0;
    chk("osc_wake", 1, osc_enable);
    chk("init_done", 1, init_done);
    wt(0, 3);
    chk("active", 0, sleep_en);
    repeat (2) @(negedge clock);
    chk("ready", 1, link_ready);
    wt(1, SC + 20);
    chk("osc_off", 0, osc_enable);
    $display("wake test done");
  endtask : t_wake
  task automatic t_busy();
    func_busy = 1;
    repeat (2) @(negedge clock);
    chk("busy_wake", 0, sleep_en);
    repeat (SC + 10) @(negedge clock);
    chk("busy_hold", 0, sleep_en);
    func_busy = 0;
    repeat (SC - 10) @(negedge clock);
    wake = 1;
    @(negedge clock);
    wake = 0;
    repeat (SC - 5) @(negedge clock);
    chk("restart", 0, sleep_en);
    wt(1, 40);
    chk("resleep", 1, sleep_en);
    $display("busy test done");
  endtask : t_busy
  // Second start-up lands while active, so reset hits live registers
  initial
  begin
    t_start();
    t_wake();
    t_busy();
    func_busy = 1;
    @(negedge clock);
    t_start();
    repeat (300) @(negedge clock);
    final_report();
  end
endmodule : tb_top
